// ---- inc/scr_defs.vh ----
// Register map, field positions, reset values and timing constants of the control registers.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// ***************************************************************
// Serial frame layout
// ***************************************************************
`define SCR_FRAME_BITS 5'd24
`define SCR_HEADER_BITS 5'd16
`define SCR_ADDR_W 15
`define SCR_RW_BIT 15

// ***************************************************************
// Register offsets
// ***************************************************************
`define SCR_ADDR_RESYNC_DELAY_COUNT_MID 15'h0026
`define SCR_ADDR_RESYNC_DELAY_COUNT_HIGH 15'h0027
`define SCR_ADDR_MODULATOR_OPTIONS 15'h0028
`define SCR_ADDR_OUTPUT_AMPLITUDE 15'h0029
`define SCR_ADDR_PHASE_POLARITY_POWER 15'h002a
`define SCR_ADDR_MAIN_POWER_DOWN 15'h002b
`define SCR_ADDR_LOCK_DETECT_CONFIG 15'h002c
`define SCR_ADDR_CLOCK_GATING_LOCK_CTRL 15'h002d
`define SCR_REG_COUNT 8

// ***************************************************************
// Reset values
// ***************************************************************
`define SCR_RST_DEFAULT 8'h00
`define SCR_RST_PHASE_POLARITY_POWER 8'h04
`define SCR_RST_MAIN_POWER_DOWN 8'h83

// ***************************************************************
// Field positions
// ***************************************************************
`define SCR_BIT_LSB_INCREMENT 6
`define SCR_BIT_AUX_MODULATOR 5
`define SCR_AMP2_MSB 7
`define SCR_AMP2_LSB 4
`define SCR_AMP1_MSB 3
`define SCR_AMP1_LSB 0
`define SCR_BIT_PHASE_DIRECTION 6
`define SCR_BIT_SYNC_OFF 4
`define SCR_BIT_REFDET_OFF 2
`define SCR_BIT_CHIP_OFF 7
`define SCR_BIT_LOCKDET_OFF 3
`define SCR_BIT_BUF1_OFF 1
`define SCR_BIT_BUF2_OFF 0
`define SCR_WIN_MSB 7
`define SCR_WIN_LSB 5
`define SCR_COUNT_MSB 4
`define SCR_COUNT_LSB 0
`define SCR_BIT_FEEDBACK_GATE 7
`define SCR_BIT_REFERENCE_GATE 6
`define SCR_BIT_LOL_ENABLE 5
`define SCR_BIT_WINDOW_ENABLE 4
`define SCR_BIT_LOCK_CLEAR 2

// ***************************************************************
// Lock count formula terms
// ***************************************************************
`define SCR_LOCK_EVEN_BASE 24'd24
`define SCR_LOCK_ODD_BASE 24'd32
`define SCR_LOCK_OFFSET 24'd3

`endif

// ---- verilog/scr_spi_slave.v ----
// Serial register port: synchronises the pins and turns frames into register writes and reads.
`include "scr_defs.vh"

module scr_spi_slave (
	input wire clk,
	input wire rst_b,
	input wire i_sclk,
	input wire i_cs_b,
	input wire i_sdi,
	input wire [7:0] i_rdata,
	output reg o_sdo,
	output reg o_sdo_oe,
	output reg o_wr_pulse,
	output reg [`SCR_ADDR_W-1:0] o_addr,
	output reg [7:0] o_wdata
);

	reg sclk_s1, sclk_s2, sclk_s3;
	reg cs_s1, cs_s2;
	reg sdi_s1, sdi_s2;
	reg [23:0] shreg;
	reg [4:0] bit_cnt;
	reg is_read;
	reg load_pend;
	reg [7:0] rd_sh;
	wire rise = sclk_s2 & ~sclk_s3;
	wire fall = ~sclk_s2 & sclk_s3;
	wire [23:0] shift_in = {shreg[22:0], sdi_s2};

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
		end else begin
			sclk_s1 <= i_sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= i_cs_b;
			cs_s2 <= cs_s1;
			sdi_s1 <= i_sdi;
			sdi_s2 <= sdi_s1;
		end
	end

	// ***************************************************************
	// Frame engine
	// ***************************************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shreg <= 24'h000000;
			bit_cnt <= 5'h00;
			is_read <= 1'b0;
			load_pend <= 1'b0;
			rd_sh <= 8'h00;
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
			o_wr_pulse <= 1'b0;
			o_addr <= {`SCR_ADDR_W{1'b0}};
			o_wdata <= 8'h00;
		end else begin
			o_wr_pulse <= 1'b0;
			load_pend <= 1'b0;
			if (load_pend) begin
				rd_sh <= i_rdata;
			end
			if (cs_s2) begin
				bit_cnt <= 5'h00;
				is_read <= 1'b0;
				o_sdo_oe <= 1'b0;
				o_sdo <= 1'b0;
			end else if (rise && bit_cnt < `SCR_FRAME_BITS) begin
				// Bits past the 24th are ignored; one register per frame.
				shreg <= shift_in;
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == `SCR_HEADER_BITS - 5'h01) begin
					o_addr <= shift_in[`SCR_ADDR_W-1:0];
					is_read <= shift_in[`SCR_RW_BIT];
					o_sdo_oe <= shift_in[`SCR_RW_BIT];
					load_pend <= 1'b1;
				end
				if (bit_cnt == `SCR_FRAME_BITS - 5'h01 && !is_read) begin
					o_wdata <= shift_in[7:0];
					o_wr_pulse <= 1'b1;
				end
			end else if (fall && is_read && bit_cnt >= `SCR_HEADER_BITS) begin
				o_sdo <= rd_sh[7];
				rd_sh <= {rd_sh[6:0], 1'b0};
			end
		end
	end

endmodule

// ---- verilog/scr_lock_detector.v ----
// Lock detector: counts in-window phase-detector cycles up to a target set by a five-bit code.
`include "scr_defs.vh"

module scr_lock_detector #(
	parameter CNT_W = 24
) (
	input wire clk,
	input wire rst_b,
	input wire i_pfd_event,
	input wire i_in_window,
	input wire i_hold,
	input wire i_loss_enable,
	input wire [4:0] i_count_code,
	output reg o_locked
);

	reg [CNT_W-1:0] count;
	wire [CNT_W-1:0] target;

	function [CNT_W-1:0] lock_target;
		input [4:0] code;
		begin
			if (code[0]) begin
				lock_target = (`SCR_LOCK_ODD_BASE << code[4:1]) + `SCR_LOCK_OFFSET;
			end else begin
				lock_target = (`SCR_LOCK_EVEN_BASE << code[4:1]) + `SCR_LOCK_OFFSET;
			end
		end
	endfunction

	assign target = lock_target(i_count_code);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= {CNT_W{1'b0}};
			o_locked <= 1'b0;
		end else if (i_hold) begin
			count <= {CNT_W{1'b0}};
			o_locked <= 1'b0;
		end else if (i_pfd_event) begin
			if (!i_in_window) begin
				count <= {CNT_W{1'b0}};
				if (i_loss_enable) begin
					o_locked <= 1'b0;
				end
			end else if (count + {{(CNT_W-1){1'b0}}, 1'b1} >= target) begin
				count <= target;
				o_locked <= 1'b1;
			end else begin
				count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// ---- verilog/scr_ctrl_regs.v ----
// Control register bank of the synthesizer: storage, serial access, resync timer and lock logic.
`include "scr_defs.vh"

module scr_ctrl_regs #(
	parameter LOCK_CNT_W = 24
) (
	input wire I_REF_CLK,
	input wire I_RST_B,
	input wire I_SCLK,
	input wire I_CS_B,
	input wire I_SDI,
	output wire O_SDO,
	output wire O_SDO_OE,
	input wire I_PFD_TOGGLE,
	input wire I_PHASE_IN_WINDOW,
	input wire I_RESYNC_TRIGGER,
	input wire [7:0] I_RESYNC_DELAY_COUNT_LOW,
	output reg O_RESYNC_APPLY,
	output reg O_RESYNC_PENDING,
	output wire O_MODULATOR_LSB_INCREMENT,
	output wire O_AUX_MODULATOR_ENABLE,
	output wire [3:0] O_FIRST_OUTPUT_AMPLITUDE,
	output wire [3:0] O_SECOND_OUTPUT_AMPLITUDE,
	output wire O_PHASE_SHIFT_DIRECTION,
	output wire O_SYNC_POWER_OFF,
	output wire O_REFERENCE_DETECTOR_POWER_OFF,
	output wire O_CHIP_POWER_OFF,
	output wire O_LOCK_DETECTOR_POWER_OFF,
	output wire O_FIRST_BUFFER_POWER_OFF,
	output wire O_SECOND_BUFFER_POWER_OFF,
	output wire [2:0] O_LOCK_WINDOW_WIDTH,
	output wire O_LOCK_WINDOW_ENABLE,
	output wire O_FEEDBACK_CLOCK_GATE,
	output wire O_REFERENCE_CLOCK_GATE,
	output wire O_LOCK_DETECT
);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	localparam [2:0] IDX_RESYNC_MID = 3'h0;
	localparam [2:0] IDX_RESYNC_HIGH = 3'h1;
	localparam [2:0] IDX_MOD_OPTIONS = 3'h2;
	localparam [2:0] IDX_AMPLITUDE = 3'h3;
	localparam [2:0] IDX_PHASE_POWER = 3'h4;
	localparam [2:0] IDX_MAIN_POWER = 3'h5;
	localparam [2:0] IDX_LOCK_CONFIG = 3'h6;
	localparam [2:0] IDX_GATING = 3'h7;

	wire wr_pulse;
	wire [`SCR_ADDR_W-1:0] addr;
	wire [7:0] wdata;
	reg [7:0] rdata;
	reg addr_hit;
	reg [2:0] idx;
	reg [7:0] regs [0:`SCR_REG_COUNT-1];

	reg pfd_s1, pfd_s2, pfd_s3;
	reg win_s1, win_s2;
	wire pfd_event;

	reg [23:0] resync_count;
	wire [23:0] resync_delay_count;

	wire lock_hold;

	wire [7:0] mod_options;
	wire [7:0] amplitude;
	wire [7:0] phase_power;
	wire [7:0] main_power;
	wire [7:0] lock_config;
	wire [7:0] gating;

	// ***************************************************************
	// Serial register port
	// ***************************************************************
	scr_spi_slave u_spi (
		.clk(I_REF_CLK),
		.rst_b(I_RST_B),
		.i_sclk(I_SCLK),
		.i_cs_b(I_CS_B),
		.i_sdi(I_SDI),
		.i_rdata(rdata),
		.o_sdo(O_SDO),
		.o_sdo_oe(O_SDO_OE),
		.o_wr_pulse(wr_pulse),
		.o_addr(addr),
		.o_wdata(wdata)
	);

	// ***************************************************************
	// Address decode
	// ***************************************************************
	// Each offset of the bank maps to one storage slot; every other address misses.
	always @* begin
		addr_hit = 1'b1;
		if (addr == `SCR_ADDR_RESYNC_DELAY_COUNT_MID) begin
			idx = IDX_RESYNC_MID;
		end else if (addr == `SCR_ADDR_RESYNC_DELAY_COUNT_HIGH) begin
			idx = IDX_RESYNC_HIGH;
		end else if (addr == `SCR_ADDR_MODULATOR_OPTIONS) begin
			idx = IDX_MOD_OPTIONS;
		end else if (addr == `SCR_ADDR_OUTPUT_AMPLITUDE) begin
			idx = IDX_AMPLITUDE;
		end else if (addr == `SCR_ADDR_PHASE_POLARITY_POWER) begin
			idx = IDX_PHASE_POWER;
		end else if (addr == `SCR_ADDR_MAIN_POWER_DOWN) begin
			idx = IDX_MAIN_POWER;
		end else if (addr == `SCR_ADDR_LOCK_DETECT_CONFIG) begin
			idx = IDX_LOCK_CONFIG;
		end else if (addr == `SCR_ADDR_CLOCK_GATING_LOCK_CTRL) begin
			idx = IDX_GATING;
		end else begin
			addr_hit = 1'b0;
			idx = IDX_RESYNC_MID;
		end
	end

	// Addresses outside this bank read as zero and ignore writes.
	always @* begin
		if (addr_hit) begin
			rdata = regs[idx];
		end else begin
			rdata = 8'h00;
		end
	end

	// ***************************************************************
	// Register storage
	// ***************************************************************
	// Reserved bits are stored and read back as written.
	function [7:0] reset_value;
		input integer index;
		begin
			if (index == IDX_PHASE_POWER) begin
				reset_value = `SCR_RST_PHASE_POLARITY_POWER;
			end else if (index == IDX_MAIN_POWER) begin
				reset_value = `SCR_RST_MAIN_POWER_DOWN;
			end else begin
				reset_value = `SCR_RST_DEFAULT;
			end
		end
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < `SCR_REG_COUNT; gi = gi + 1) begin : g_reg
			always @(posedge I_REF_CLK or negedge I_RST_B) begin
				if (!I_RST_B) begin
					regs[gi] <= reset_value(gi);
				end else if (wr_pulse && addr_hit && idx == gi) begin
					regs[gi] <= wdata;
				end
			end
		end
	endgenerate

	assign mod_options = regs[IDX_MOD_OPTIONS];
	assign amplitude = regs[IDX_AMPLITUDE];
	assign phase_power = regs[IDX_PHASE_POWER];
	assign main_power = regs[IDX_MAIN_POWER];
	assign lock_config = regs[IDX_LOCK_CONFIG];
	assign gating = regs[IDX_GATING];

	// ***************************************************************
	// Analog control outputs
	// ***************************************************************
	// modulator increment
	assign O_MODULATOR_LSB_INCREMENT = mod_options[`SCR_BIT_LSB_INCREMENT];
	assign O_AUX_MODULATOR_ENABLE = mod_options[`SCR_BIT_AUX_MODULATOR];

	assign O_SECOND_OUTPUT_AMPLITUDE = amplitude[`SCR_AMP2_MSB:`SCR_AMP2_LSB];
	assign O_FIRST_OUTPUT_AMPLITUDE = amplitude[`SCR_AMP1_MSB:`SCR_AMP1_LSB];

	assign O_PHASE_SHIFT_DIRECTION = phase_power[`SCR_BIT_PHASE_DIRECTION];
	assign O_SYNC_POWER_OFF = phase_power[`SCR_BIT_SYNC_OFF];
	assign O_REFERENCE_DETECTOR_POWER_OFF = phase_power[`SCR_BIT_REFDET_OFF];

	assign O_CHIP_POWER_OFF = main_power[`SCR_BIT_CHIP_OFF];
	assign O_LOCK_DETECTOR_POWER_OFF = main_power[`SCR_BIT_LOCKDET_OFF];
	assign O_FIRST_BUFFER_POWER_OFF = main_power[`SCR_BIT_BUF1_OFF];
	assign O_SECOND_BUFFER_POWER_OFF = main_power[`SCR_BIT_BUF2_OFF];

	assign O_LOCK_WINDOW_WIDTH = lock_config[`SCR_WIN_MSB:`SCR_WIN_LSB];
	assign O_LOCK_WINDOW_ENABLE = gating[`SCR_BIT_WINDOW_ENABLE];
	assign O_FEEDBACK_CLOCK_GATE = gating[`SCR_BIT_FEEDBACK_GATE];
	assign O_REFERENCE_CLOCK_GATE = gating[`SCR_BIT_REFERENCE_GATE];

	// ***************************************************************
	// Phase-detector event and window synchronisers
	// ***************************************************************
	// The phase-detector tick arrives as a toggle so that no period is lost.
	always @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pfd_s1 <= 1'b0;
			pfd_s2 <= 1'b0;
			pfd_s3 <= 1'b0;
			win_s1 <= 1'b0;
			win_s2 <= 1'b0;
		end else begin
			pfd_s1 <= I_PFD_TOGGLE;
			pfd_s2 <= pfd_s1;
			pfd_s3 <= pfd_s2;
			win_s1 <= I_PHASE_IN_WINDOW;
			win_s2 <= win_s1;
		end
	end

	assign pfd_event = pfd_s2 ^ pfd_s3;

	// ***************************************************************
	// Resynchronisation wait timer
	// ***************************************************************
	assign resync_delay_count = {regs[IDX_RESYNC_HIGH], regs[IDX_RESYNC_MID], I_RESYNC_DELAY_COUNT_LOW};

	// The wait value is captured at the trigger, so later writes leave a running wait alone.
	// resync delay timer
	always @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			resync_count <= 24'h000000;
			O_RESYNC_PENDING <= 1'b0;
			O_RESYNC_APPLY <= 1'b0;
		end else begin
			O_RESYNC_APPLY <= 1'b0;
			if (O_SYNC_POWER_OFF) begin
				// A powered-down sync path drops any waiting request.
				resync_count <= 24'h000000;
				O_RESYNC_PENDING <= 1'b0;
			end else if (I_RESYNC_TRIGGER) begin
				// A new trigger restarts the wait from the full value.
				resync_count <= resync_delay_count;
				O_RESYNC_PENDING <= 1'b1;
			end else if (O_RESYNC_PENDING) begin
				if (resync_count == 24'h000000) begin
					O_RESYNC_APPLY <= 1'b1;
					O_RESYNC_PENDING <= 1'b0;
				end else if (pfd_event) begin
					resync_count <= resync_count - 24'h000001;
				end
			end
		end
	end

	// ***************************************************************
	// Lock detector
	// ***************************************************************
	// Chip power-down holds the detector too, since phase-detector events mean nothing then.
	// hold unlocked
	assign lock_hold = gating[`SCR_BIT_LOCK_CLEAR] | O_LOCK_DETECTOR_POWER_OFF |
		O_CHIP_POWER_OFF;

	scr_lock_detector #(
		.CNT_W(LOCK_CNT_W)
	) u_lock (
		.clk(I_REF_CLK),
		.rst_b(I_RST_B),
		.i_pfd_event(pfd_event),
		.i_in_window(win_s2),
		.i_hold(lock_hold),
		.i_loss_enable(gating[`SCR_BIT_LOL_ENABLE]),
		.i_count_code(lock_config[`SCR_COUNT_MSB:`SCR_COUNT_LSB]),
		.o_locked(O_LOCK_DETECT)
	);

endmodule

// ---- testbench/scr_spi_host.sv ----
// Serial host model that drives register frames and samples read data.
module scr_spi_host (
	input wire logic clk,
	input wire logic sdo,
	output logic sclk,
	output logic cs_b,
	output logic sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		sdi = 1'b0;
	end
	// A deselected data line keeps changing so that no stale bit can pass for data.
	always @(negedge clk) begin
		if (cs_b) begin
			sdi <= ~sdi;
		end
	end
	task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [23:0] frame;
		frame = {rd, addr, wd};
		rdat = 8'h00;
		@(posedge clk) #1;
		cs_b = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = frame[i];
			repeat (5) @(posedge clk);
			#1 sclk = 1'b1;
			if (i < 8) begin
				rdat[i] = sdo;
			end
			repeat (5) @(posedge clk);
			#1 sclk = 1'b0;
		end
		repeat (5) @(posedge clk);
		#1 cs_b = 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ---- testbench/scr_ctrl_regs_asserts.sv ----
// Port-level checks of the control register bank.
module scr_ctrl_regs_asserts #(
	parameter LOCK_CNT_W = 24
) (
	input wire I_REF_CLK,
	input wire I_RST_B,
	input wire I_CS_B,
	input wire I_PFD_TOGGLE,
	input wire I_RESYNC_TRIGGER,
	input wire O_RESYNC_APPLY,
	input wire O_RESYNC_PENDING,
	input wire O_SYNC_POWER_OFF,
	input wire O_REFERENCE_DETECTOR_POWER_OFF,
	input wire O_CHIP_POWER_OFF,
	input wire O_LOCK_DETECTOR_POWER_OFF,
	input wire O_FIRST_BUFFER_POWER_OFF,
	input wire O_SECOND_BUFFER_POWER_OFF,
	input wire O_LOCK_DETECT,
	input wire O_SDO_OE
);
	logic [7:0] tog_cnt;
	logic tog_d;
	default clocking dc @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_B);
	// Counts toggles since the lock detector or chip was last powered off; lock needs at least 27.
	always @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tog_cnt <= 8'h00;
			tog_d <= 1'b0;
		end else begin
			tog_d <= I_PFD_TOGGLE;
			if (O_LOCK_DETECTOR_POWER_OFF || O_CHIP_POWER_OFF) begin
				tog_cnt <= 8'h00;
			end else if (tog_d != I_PFD_TOGGLE && tog_cnt != 8'hff) begin
				tog_cnt <= tog_cnt + 8'h01;
			end
		end
	end
	sequence sync_held_off;
		O_SYNC_POWER_OFF [*2];
	endsequence
	sequence wait_closed;
		!O_RESYNC_PENDING ##1 !O_RESYNC_APPLY;
	endsequence
	a_reset_power: assert property (
		$rose(I_RST_B) |-> O_CHIP_POWER_OFF && O_FIRST_BUFFER_POWER_OFF && O_SECOND_BUFFER_POWER_OFF
	) else $error("power-down reset value wrong");
	a_reset_detector: assert property (
		$rose(I_RST_B) |-> O_REFERENCE_DETECTOR_POWER_OFF && !O_SYNC_POWER_OFF
	) else $error("detector reset value wrong");
	a_apply_single: assert property (
		O_RESYNC_APPLY |-> $past(O_RESYNC_PENDING) ##0 wait_closed
	) else $error("apply pulse malformed");
	a_trigger_starts: assert property (
		I_RESYNC_TRIGGER && !O_SYNC_POWER_OFF |=> O_RESYNC_PENDING
	) else $error("trigger did not start wait");
	a_sync_off_idle: assert property (
		sync_held_off |-> !O_RESYNC_PENDING && !O_RESYNC_APPLY
	) else $error("resync active while powered down");
	a_lock_held_off: assert property (
		O_LOCK_DETECTOR_POWER_OFF || O_CHIP_POWER_OFF |-> ##2 !O_LOCK_DETECT
	) else $error("lock while detector off");
	a_lock_needs_events: assert property (
		$rose(O_LOCK_DETECT) |-> tog_cnt >= 8'd27
	) else $error("lock flagged too early");
	a_oe_after_frame: assert property (
		I_CS_B [*5] |-> !O_SDO_OE
	) else $error("data out enabled while deselected");
endmodule
bind scr_ctrl_regs scr_ctrl_regs_asserts #(.LOCK_CNT_W(LOCK_CNT_W)) chk (
	.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B), .I_PFD_TOGGLE(I_PFD_TOGGLE),
	.I_RESYNC_TRIGGER(I_RESYNC_TRIGGER), .O_RESYNC_APPLY(O_RESYNC_APPLY),
	.O_RESYNC_PENDING(O_RESYNC_PENDING), .O_SYNC_POWER_OFF(O_SYNC_POWER_OFF),
	.O_REFERENCE_DETECTOR_POWER_OFF(O_REFERENCE_DETECTOR_POWER_OFF),
	.O_CHIP_POWER_OFF(O_CHIP_POWER_OFF), .O_LOCK_DETECTOR_POWER_OFF(O_LOCK_DETECTOR_POWER_OFF),
	.O_FIRST_BUFFER_POWER_OFF(O_FIRST_BUFFER_POWER_OFF),
	.O_SECOND_BUFFER_POWER_OFF(O_SECOND_BUFFER_POWER_OFF), .O_LOCK_DETECT(O_LOCK_DETECT),
	.O_SDO_OE(O_SDO_OE)
);

// ---- testbench/tb_top.sv ----
// Self-checking bench of the control register bank.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, sclk, cs_b, sdi, sdo, sdo_oe, pfd, win, trig, apply, pend, lock;
	logic lsb, aux, dir, syoff, rdoff, choff, ldoff, b1off, b2off, wen, fbg, rfg;
	logic [3:0] amp1, amp2;
	logic [2:0] wwid;
	logic [7:0] wlow;
	logic [7:0] sh [8];
	logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h83, 8'h00, 8'h00};
	logic [7:0] msk [8] = '{8'hff, 8'hff, 8'h60, 8'hff, 8'h54, 8'h8b, 8'hff, 8'hf4};
	logic [31:0] seed = 32'h0000c555;
	int err_count = 0;
	int check_count = 0;
	wire [22:0] obs = {lsb, aux, amp2, amp1, dir, syoff, rdoff, choff, ldoff, b1off, b2off,
		wwid, fbg, rfg, wen};
	// A released data line shows the inverse, so a missing output enable reads wrong.
	wire sdo_line = sdo_oe ? sdo : ~sdo;
	scr_ctrl_regs #(.LOCK_CNT_W(24)) uut (
		.I_REF_CLK(clk), .I_RST_B(rst_b), .I_SCLK(sclk), .I_CS_B(cs_b), .I_SDI(sdi),
		.O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_PFD_TOGGLE(pfd), .I_PHASE_IN_WINDOW(win),
		.I_RESYNC_TRIGGER(trig), .I_RESYNC_DELAY_COUNT_LOW(wlow), .O_RESYNC_APPLY(apply),
		.O_RESYNC_PENDING(pend), .O_MODULATOR_LSB_INCREMENT(lsb),
		.O_AUX_MODULATOR_ENABLE(aux), .O_FIRST_OUTPUT_AMPLITUDE(amp1),
		.O_SECOND_OUTPUT_AMPLITUDE(amp2), .O_PHASE_SHIFT_DIRECTION(dir),
		.O_SYNC_POWER_OFF(syoff), .O_REFERENCE_DETECTOR_POWER_OFF(rdoff),
		.O_CHIP_POWER_OFF(choff), .O_LOCK_DETECTOR_POWER_OFF(ldoff),
		.O_FIRST_BUFFER_POWER_OFF(b1off), .O_SECOND_BUFFER_POWER_OFF(b2off),
		.O_LOCK_WINDOW_WIDTH(wwid), .O_LOCK_WINDOW_ENABLE(wen),
		.O_FEEDBACK_CLOCK_GATE(fbg), .O_REFERENCE_CLOCK_GATE(rfg), .O_LOCK_DETECT(lock)
	);
	scr_spi_host host (.clk(clk), .sdo(sdo_line), .sclk(sclk), .cs_b(cs_b), .sdi(sdi));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [22:0] exp_out();
		return {sh[2][6:5], sh[3], sh[4][6], sh[4][4], sh[4][2], sh[5][7], sh[5][3],
			sh[5][1:0], sh[6][7:5], sh[7][7:6], sh[7][4]};
	endfunction
	function automatic int tgt(input int n);
		return (n % 2 == 0) ? (24 << (n / 2)) + 3 : (32 << ((n - 1) / 2)) + 3;
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic put(input int i, input logic [7:0] d);
		logic [7:0] x;
		if (i >= 0 && i < 8) begin
			sh[i] = d;
		end
		host.xfer(1'b0, 15'h0026 + 15'(i), d, x);
	endtask
	task automatic reg_read(input int i, input logic [7:0] e);
		logic [7:0] x;
		host.xfer(1'b1, 15'h0026 + 15'(i), 8'h00, x);
		check("read", e, x);
	endtask
	task automatic putchk(input int i, input logic [7:0] d);
		put(i, d);
		reg_read(i, d);
		check("outputs", exp_out(), obs);
	endtask
	task automatic trigger();
		@(posedge clk) #1;
		trig = 1'b1;
		@(posedge clk) #1;
		trig = 1'b0;
	endtask
	task automatic resync(input logic [7:0] lo);
		int n;
		n = 0;
		@(posedge clk) #1;
		wlow = lo;
		trigger();
		repeat (1000) begin
			repeat (6) begin
				@(posedge clk) #1;
				if (apply === 1'b1) begin
					check("resync_delay_count", {sh[1], sh[0], lo}, n);
					return;
				end
			end
			pfd = ~pfd;
			n++;
		end
		check("resync apply", 1, 0);
	endtask
	task automatic pulses(input int n, input logic w);
		repeat (n) begin
			@(posedge clk) #1;
			win = w;
			pfd = ~pfd;
			repeat (5) @(posedge clk);
		end
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#1_500_000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		rst_b = 1'b0;
		pfd = 1'b0;
		win = 1'b0;
		trig = 1'b0;
		wlow = 8'h00;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			sh[i] = rst_val[i];
			reg_read(i, rst_val[i]);
		end
		check("outputs", exp_out(), obs);
		put(8, 8'h5a);
		reg_read(8, 8'h00);
		reg_read(-1, 8'h00);
		putchk(3, 8'hf0);
		putchk(3, 8'h0f);
		repeat (3) begin
			for (int i = 0; i < 8; i++) begin
				putchk(i, rnd() & msk[i]);
			end
		end
		put(4, 8'h00);
		put(0, 8'h00);
		put(1, 8'h00);
		resync(8'h00);
		resync(8'h01);
		resync(rnd() & 8'h0f);
		put(0, 8'h01);
		resync(8'h02);
		trigger();
		check("pending start", 1, pend);
		put(4, 8'h10);
		check("pending cancel", 0, pend);
		trigger();
		#50;
		check("pending", 0, pend);
		put(4, 8'h00);
		put(5, 8'h00);
		for (int n = 0; n < 6; n++) begin
			put(6, 8'(n));
			put(7, 8'h20);
			pulses(tgt(n) - 1, 1'b1);
			check("lock early", 0, lock);
			pulses(1, 1'b1);
			check("lock", 1, lock);
			put(7, 8'h00);
			pulses(1, 1'b0);
			check("lock kept", 1, lock);
			if (n % 2 == 0) begin
				put(7, 8'h24);
				pulses(4, 1'b1);
				check("lock cleared", 0, lock);
			end else begin
				put(5, 8'h08);
				pulses(4, 1'b1);
				check("lock powered off", 0, lock);
				put(5, 8'h00);
			end
			put(7, 8'h20);
			pulses(tgt(n), 1'b1);
			check("lock again", 1, lock);
			pulses(1, 1'b0);
			check("lock lost", 0, lock);
		end
		pulses(tgt(5), 1'b1);
		trigger();
		@(posedge clk) #1;
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		check("pending after reset", 0, pend);
		check("lock after reset", 0, lock);
		for (int i = 0; i < 8; i++) begin
			sh[i] = rst_val[i];
			reg_read(i, rst_val[i]);
		end
		check("outputs", exp_out(), obs);
		tally_and_finish();
	end
endmodule
